// ===== verilog/motion_pkg.sv
// ==========================================================
// Notes on behaviour
// - Handset test command toggles walk test when enabled
// - Handset test ends download-entered walk test
// - Leaving walk test resets units, sends ends
// - Supply-loss reset clears walk test
// - LED on in walk test, optionally motion
// - LED shows all sectors, brightness ignored
// - Up to five independent evaluation units
// - Each unit drives at most two outputs
// - First unit always enabled, others configurable
// - Corridor start only below twilight, optional delay
// - Corridor end after 10 s plus extra
// - Brightness-independent twilight: every motion starts
// - Twilight replaceable by teach or bus value
// - Presence: above switch-off, end after delay
// - Presence end after 10 s plus extra
// - Presence: mid-band motion gives no switch-on
// - Corridor output switchable while disabled or manual
// - Walk test: no processing, no telegrams
package motion_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TICK_MS = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned BASE_DELAY_S = 10;
	localparam int unsigned UNIT_COUNT = 5;
	localparam int unsigned SECTOR_COUNT = 3;
	localparam int unsigned DELAY_W = 16;
	localparam int unsigned BRIGHT_W = 16;

	// ==========================================================
	// Configuration encodings
	typedef enum logic [1:0] {
		APP_CORRIDOR = 2'h0,
		APP_PRESENCE = 2'h1,
		APP_ALERT = 2'h2
	} app_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EVAL = 2'h1,
		ST_ACTIVE = 2'h3,
		ST_HOLD = 2'h2
	} unit_state_e;

	typedef struct packed {
		logic enable;
		app_e app;
		logic bright_indep;
		logic [1:0] out_enable;
		logic [DELAY_W-1:0] eval_delay_s;
		logic [DELAY_W-1:0] extra_delay_s;
		logic [DELAY_W-1:0] off_delay_s;
		logic use_off_delay;
		logic [BRIGHT_W-1:0] twilight_cfg;
		logic [BRIGHT_W-1:0] off_bright;
		logic [SECTOR_COUNT-1:0] sectors;
	} unit_cfg_s;

	typedef struct packed {
		logic start;
		logic stop;
		logic [1:0] objects;
	} telegram_s;

endpackage : motion_pkg

// ===== verilog/second_tick.sv
`timescale 1ns/1ps
// ==========================================================
// Divider giving a one-cycle pulse per time-base period
module second_tick #(
	parameter int unsigned CYCLES = motion_pkg::TICK_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	output logic tick_out
);
	import motion_pkg::*;

	logic [31:0] count_reg;
	wire logic wrap = (count_reg == 32'(CYCLES - 1));

	// Free-running count; tick ends each period
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count_reg <= 32'h0;
			tick_out <= 1'b0;
		end else begin
			count_reg <= wrap ? 32'h0 : count_reg + 32'h1;
			tick_out <= wrap;
		end
	end

endmodule : second_tick

// ===== verilog/motion_eval_unit.sv
`timescale 1ns/1ps
// ==========================================================
// One evaluation unit: corridor or presence behaviour
module motion_eval_unit (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic tick_in,
	input motion_pkg::unit_cfg_s cfg_in,
	input wire logic force_en_in,
	input wire logic motion_in,
	input wire logic [motion_pkg::BRIGHT_W-1:0] bright_in,
	input wire logic [motion_pkg::BRIGHT_W-1:0] twilight_in,
	input wire logic hold_in,
	input wire logic abort_in,
	input wire logic manual_on_in,
	input wire logic manual_off_in,
	output motion_pkg::telegram_s tel_out,
	output logic active_out
);
	import motion_pkg::*;

	unit_state_e state_reg;
	logic [DELAY_W:0] timer_reg;
	logic bright_off_reg;

	// ==========================================================
	// Decode
	wire logic enabled = cfg_in.enable | force_en_in;
	wire logic is_presence = (cfg_in.app == APP_PRESENCE);
	wire logic dark = cfg_in.bright_indep | (bright_in < twilight_in);
	wire logic too_bright = !cfg_in.bright_indep &&
		(bright_in > cfg_in.off_bright);
	wire logic [DELAY_W:0] end_delay =
		(DELAY_W+1)'(BASE_DELAY_S) + {1'b0, cfg_in.extra_delay_s};
	wire logic [DELAY_W:0] off_delay = cfg_in.use_off_delay ?
		{1'b0, cfg_in.off_delay_s} : end_delay;
	wire logic timer_done = (timer_reg == '0);
	// Manual path works even when disabled
	wire logic man_on = manual_on_in && (state_reg == ST_IDLE);
	wire logic man_off = manual_off_in && (state_reg != ST_IDLE);
	wire logic run = enabled && !hold_in;
	// Motion retriggers only while no brightness switch-off is pending
	wire logic retrig = motion_in && !bright_off_reg;

	// Corridor and presence state machine and timers
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= ST_IDLE;
			timer_reg <= '0;
			bright_off_reg <= 1'b0;
			tel_out <= '0;
		end else begin
			tel_out.start <= 1'b0;
			tel_out.stop <= 1'b0;
			tel_out.objects <= cfg_in.out_enable;
			if (abort_in) begin
				// Back to basic state with end telegram
				if (state_reg != ST_IDLE)
					tel_out.stop <= 1'b1;
				state_reg <= ST_IDLE;
				timer_reg <= '0;
				bright_off_reg <= 1'b0;
			end else if (man_off) begin
				tel_out.stop <= 1'b1;
				state_reg <= ST_IDLE;
				bright_off_reg <= 1'b0;
			end else if (man_on) begin
				tel_out.start <= 1'b1;
				state_reg <= ST_HOLD;
				timer_reg <= end_delay;
			end else if (run) begin
				case (state_reg)
				ST_IDLE: begin
					if (motion_in && dark) begin
						state_reg <= ST_EVAL;
						timer_reg <= {1'b0, cfg_in.eval_delay_s};
					end
				end
				ST_EVAL: begin
					if (timer_done) begin
						tel_out.start <= 1'b1;
						state_reg <= ST_ACTIVE;
						timer_reg <= end_delay;
					end else if (tick_in) begin
						timer_reg <= timer_reg - 1'b1;
					end
				end
				ST_ACTIVE, ST_HOLD: begin
					// Corridor ignores brightness once on
					if (is_presence && too_bright && !bright_off_reg) begin
						bright_off_reg <= 1'b1;
						timer_reg <= off_delay;
					end else if (retrig) begin
						timer_reg <= end_delay;
						state_reg <= ST_ACTIVE;
					end else if (timer_done) begin
						tel_out.stop <= 1'b1;
						state_reg <= ST_IDLE;
						bright_off_reg <= 1'b0;
					end else if (tick_in) begin
						timer_reg <= timer_reg - 1'b1;
					end
				end
				default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	assign active_out = (state_reg == ST_ACTIVE) || (state_reg == ST_HOLD);

endmodule : motion_eval_unit

// ===== verilog/motion_detect.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// ==========================================================
// Top: walk test, LED, five evaluation units, register port
module motion_detect #(
	parameter int unsigned TICK_LEN = motion_pkg::TICK_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [motion_pkg::SECTOR_COUNT-1:0] pir_in,
	input wire logic [motion_pkg::BRIGHT_W-1:0] bright_in,
	input wire logic handset_test_in,
	input wire logic download_done_in,
	input wire logic [motion_pkg::UNIT_COUNT-1:0] manual_on_in,
	input wire logic [motion_pkg::UNIT_COUNT-1:0] manual_off_in,
	input wire logic [motion_pkg::UNIT_COUNT-1:0] teach_in,
	input wire logic [motion_pkg::UNIT_COUNT-1:0] bus_twilight_we_in,
	input wire logic [motion_pkg::BRIGHT_W-1:0] bus_twilight_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic led_out,
	output motion_pkg::telegram_s [motion_pkg::UNIT_COUNT-1:0] tel_out
);
	import motion_pkg::*;

	// ==========================================================
	// Register map
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_UNIT0 = 8'h10;
	localparam logic [7:0] A_UNIT_STRIDE = 8'h10;
	localparam int unsigned CTRL_HANDSET = 0;
	localparam int unsigned CTRL_TESTBTN = 1;
	localparam int unsigned CTRL_LED_NORMAL = 2;
	localparam int unsigned CTRL_WALK_DL = 3;

	// ==========================================================
	// Pin synchronisers
	logic [SECTOR_COUNT-1:0] pir_meta_reg, pir_reg;
	logic test_meta_reg, test_reg, test_prev_reg;
	logic dl_meta_reg, dl_reg, dl_prev_reg;
	logic [BRIGHT_W-1:0] br_meta_reg, br_reg;

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pir_meta_reg <= '0;
			pir_reg <= '0;
			{test_meta_reg, test_reg, test_prev_reg} <= 3'h0;
			{dl_meta_reg, dl_reg, dl_prev_reg} <= 3'h0;
			br_meta_reg <= '0;
			br_reg <= '0;
		end else begin
			pir_meta_reg <= pir_in;
			pir_reg <= pir_meta_reg;
			{test_reg, test_meta_reg} <= {test_meta_reg, handset_test_in};
			test_prev_reg <= test_reg;
			{dl_reg, dl_meta_reg} <= {dl_meta_reg, download_done_in};
			dl_prev_reg <= dl_reg;
			br_meta_reg <= bright_in;
			br_reg <= br_meta_reg;
		end
	end

	// ==========================================================
	// Configuration registers
	logic [3:0] ctrl_reg;
	unit_cfg_s cfg_reg [UNIT_COUNT];
	logic [BRIGHT_W-1:0] twilight_reg [UNIT_COUNT];
	logic walk_reg;

	wire logic test_cmd = test_reg && !test_prev_reg &&
		ctrl_reg[CTRL_HANDSET] && ctrl_reg[CTRL_TESTBTN];
	wire logic dl_cmd = dl_reg && !dl_prev_reg && ctrl_reg[CTRL_WALK_DL];
	wire logic walk_exit = walk_reg && test_cmd;
	wire logic [3:0] unit_sel = 4'(addr_in[7:4] - 4'h1);
	wire logic [1:0] field_sel = addr_in[3:2];
	wire logic unit_hit = (addr_in >= A_UNIT0) &&
		(unit_sel < 4'(UNIT_COUNT));

	// Function: pack words of a unit's configuration
	function automatic logic [31:0] cfg_word(input unit_cfg_s c,
		input logic [1:0] f);
		case (f)
		2'h0: cfg_word = {15'h0, c.sectors, c.use_off_delay,
			c.out_enable, c.bright_indep, c.app, c.enable,
			7'h0}; // Low bits unused
		2'h1: cfg_word = {c.eval_delay_s, c.extra_delay_s};
		2'h2: cfg_word = {c.off_delay_s, c.off_bright};
		default: cfg_word = {16'h0, c.twilight_cfg};
		endcase
	endfunction : cfg_word

	// Walk-test mode; reset (supply loss) clears it
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			walk_reg <= 1'b0;
		else if (test_cmd)
			walk_reg <= !walk_reg;
		else if (dl_cmd)
			walk_reg <= 1'b1;
	end

	// Register writes; twilight replaceable at run time
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_reg <= 4'h0;
			for (int i = 0; i < UNIT_COUNT; i++) begin
				cfg_reg[i] <= '0;
				twilight_reg[i] <= '0;
			end
		end else begin
			if (wr_in && addr_in == A_CTRL)
				ctrl_reg <= wdata_in[3:0];
			for (int i = 0; i < UNIT_COUNT; i++) begin
				if (wr_in && unit_hit && unit_sel == 4'(i)) begin
					case (field_sel)
					2'h0: begin
						cfg_reg[i].sectors <= wdata_in[16:14];
						cfg_reg[i].use_off_delay <= wdata_in[13];
						cfg_reg[i].out_enable <= wdata_in[12:11];
						cfg_reg[i].bright_indep <= wdata_in[10];
						cfg_reg[i].app <= app_e'(wdata_in[9:8]);
						cfg_reg[i].enable <= wdata_in[7];
					end
					2'h1: begin
						cfg_reg[i].eval_delay_s <= wdata_in[31:16];
						cfg_reg[i].extra_delay_s <= wdata_in[15:0];
					end
					2'h2: begin
						cfg_reg[i].off_delay_s <= wdata_in[31:16];
						cfg_reg[i].off_bright <= wdata_in[15:0];
					end
					default: begin
						cfg_reg[i].twilight_cfg <= wdata_in[15:0];
						twilight_reg[i] <= wdata_in[15:0];
					end
					endcase
				end else if (teach_in[i]) begin
					twilight_reg[i] <= br_reg;
				end else if (bus_twilight_we_in[i]) begin
					twilight_reg[i] <= bus_twilight_in;
				end
			end
		end
	end

	// ==========================================================
	// Time base and units
	logic tick;
	logic [UNIT_COUNT-1:0] active;

	second_tick #(
		.CYCLES(TICK_LEN)
	) u_tick (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.tick_out(tick)
	);

	// Units run independently; walk test holds them
	for (genvar g = 0; g < UNIT_COUNT; g++) begin : g_unit
		wire logic unit_motion = |(pir_reg & cfg_reg[g].sectors);
		motion_eval_unit u_unit (
			.ref_clk_in(ref_clk_in),
			.nrst_in(nrst_in),
			.tick_in(tick),
			.cfg_in(cfg_reg[g]),
			.force_en_in(g == 0),
			.motion_in(unit_motion),
			.bright_in(br_reg),
			.twilight_in(twilight_reg[g]),
			.hold_in(walk_reg),
			.abort_in(walk_exit),
			.manual_on_in(manual_on_in[g] && !walk_reg),
			.manual_off_in(manual_off_in[g] && !walk_reg),
			.tel_out(tel_out[g]),
			.active_out(active[g])
		);
	end

	// ==========================================================
	// LED: any sector, brightness ignored
	wire logic any_motion = |pir_reg;
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			led_out <= 1'b0;
		else
			led_out <= walk_reg ||
				(ctrl_reg[CTRL_LED_NORMAL] && any_motion);
	end

	// ==========================================================
	// Read port: data one cycle after strobe
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		if (addr_in == A_CTRL)
			rd_mux = {28'h0, ctrl_reg};
		else if (addr_in == A_STATUS)
			rd_mux = {22'h0, pir_reg, active, walk_reg, led_out};
		else if (unit_hit)
			for (int i = 0; i < UNIT_COUNT; i++)
				if (unit_sel == 4'(i))
					rd_mux = (field_sel == 2'h3) ?
						{16'h0, twilight_reg[i]} :
						cfg_word(cfg_reg[i], field_sel);
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			rdata_out <= 32'h0;
		else if (rd_in)
			rdata_out <= rd_mux;
		else
			rdata_out <= 32'h0;
	end

endmodule : motion_detect

// ===== bench/motion_detect_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the motion block
module motion_detect_monitor (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] addr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic led_out,
	input motion_pkg::telegram_s [motion_pkg::UNIT_COUNT-1:0] tel_out
);
	import motion_pkg::*;
	logic [UNIT_COUNT-1:0] start_v;
	logic [UNIT_COUNT-1:0] stop_v;
	logic [UNIT_COUNT-1:0] on_reg;
	// Pulse vectors, one bit a unit
	always_comb begin
		for (int i = 0; i < UNIT_COUNT; i++) begin
			start_v[i] = tel_out[i].start;
			stop_v[i] = tel_out[i].stop;
		end
	end
	// Units left switched on by their telegrams
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			on_reg <= '0;
		end else begin
			on_reg <= (on_reg | start_v) & ~stop_v;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	property p_rd_idle;
		!$past(rd_in) |-> rdata_out == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("stray read data");
	property p_unmapped;
		$past(rd_in) && $past(addr_in) == 8'hF0 |-> rdata_out == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped data");
	property p_status_led;
		$past(rd_in) && $past(addr_in) == 8'h04 |->
			rdata_out[0] == $past(led_out);
	endproperty
	a_status_led: assert property (p_status_led)
		else $error("led status");
	property p_start_pulse;
		start_v != '0 |=> (start_v & $past(start_v)) == '0;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("long start");
	property p_stop_pulse;
		stop_v != '0 |=> (stop_v & $past(stop_v)) == '0;
	endproperty
	a_stop_pulse: assert property (p_stop_pulse)
		else $error("long stop");
	property p_no_both;
		(start_v & stop_v) == '0;
	endproperty
	a_no_both: assert property (p_no_both)
		else $error("start with stop");
	property p_no_restart;
		(start_v & on_reg) == '0;
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("second start");
	property p_reset_quiet;
		$rose(nrst_in) |-> !led_out && tel_out == '0 && rdata_out == 32'h0;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("reset state");
	c_start: cover property (start_v != '0);
	c_stop: cover property (stop_v != '0);
	c_led: cover property ($rose(led_out));
endmodule : motion_detect_monitor

bind motion_detect motion_detect_monitor mon (
	.ref_clk_in(ref_clk_in),
	.nrst_in(nrst_in),
	.addr_in(addr_in),
	.rd_in(rd_in),
	.rdata_out(rdata_out),
	.led_out(led_out),
	.tel_out(tel_out)
);

// ===== bench/bus_telegram_sink.sv
`timescale 1ns/1ps
// ==========================================================
// Bus side: counts start and end telegrams per unit
module bus_telegram_sink (
	input wire logic ref_clk_in,
	input motion_pkg::telegram_s [motion_pkg::UNIT_COUNT-1:0] tel_in,
	output logic [motion_pkg::UNIT_COUNT-1:0][31:0] starts_out,
	output logic [motion_pkg::UNIT_COUNT-1:0][31:0] stops_out
);
	import motion_pkg::*;
	// Bus keeps its tally across device resets
	initial begin
		starts_out = '0;
		stops_out = '0;
	end
	always @(posedge ref_clk_in) begin
		for (int i = 0; i < UNIT_COUNT; i++) begin
			starts_out[i] <= starts_out[i] + 32'(tel_in[i].start);
			stops_out[i] <= stops_out[i] + 32'(tel_in[i].stop);
		end
	end
endmodule : bus_telegram_sink

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
	import motion_pkg::*;
	logic ref_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [2:0] pir = 3'h0;
	logic [15:0] bright = 16'h0100;
	logic hs = 1'b0;
	logic dl = 1'b0;
	logic [4:0] mon = 5'h0;
	logic [4:0] moff = 5'h0;
	logic [4:0] teach = 5'h0;
	logic [4:0] twe = 5'h0;
	logic [15:0] twv = 16'h0;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic led;
	telegram_s [UNIT_COUNT-1:0] tel;
	logic [UNIT_COUNT-1:0][31:0] st;
	logic [UNIT_COUNT-1:0][31:0] sp;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	always #2.5 ref_clk_in = ~ref_clk_in;
	// Short time base so the delays fit in the run
	motion_detect #(.TICK_LEN(20)) uut (.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.pir_in(pir), .bright_in(bright), .handset_test_in(hs),
		.download_done_in(dl), .manual_on_in(mon), .manual_off_in(moff),
		.teach_in(teach), .bus_twilight_we_in(twe),
		.bus_twilight_in(twv), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .led_out(led),
		.tel_out(tel));
	bus_telegram_sink sink (.ref_clk_in(ref_clk_in), .tel_in(tel),
		.starts_out(st), .stops_out(sp));
	// ==========================================================
	// Shared tasks
	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task wait_n(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask : wait_n
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_in);
		wr <= 1'b0;
	endtask : wr_reg
	// Data stand only in the cycle after the strobe
	task rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_in);
		rd <= 1'b0;
		@(posedge ref_clk_in);
		d = rdata;
	endtask : rd_reg
	task hs_edge;
		@(posedge ref_clk_in);
		hs <= 1'b1;
		wait_n(8);
		hs <= 1'b0;
		wait_n(8);
	endtask : hs_edge
	function automatic logic [31:0] ucfg(logic [2:0] s, logic i, logic e);
		return {15'h0, s, 1'b0, 2'h1, i, APP_CORRIDOR, e, 7'h0};
	endfunction : ucfg
	// ==========================================================
	// Scenarios
	task t_regs;
		logic [31:0] d;
		rd_reg(8'h04, d);
		check("status", d, 32'h0);
		wr_reg(8'hF0, 32'hFFFF_FFFF);
		rd_reg(8'hF0, d);
		check("unmapped", d, 32'h0);
	endtask : t_regs
	// Unit 0 dark with enable cleared, unit 1 too bright, unit 2 blind
	task t_corridor;
		logic [31:0] d;
		wr_reg(8'h10, ucfg(3'h7, 1'b0, 1'b0));
		wr_reg(8'h20, ucfg(3'h7, 1'b0, 1'b1));
		wr_reg(8'h30, ucfg(3'h7, 1'b1, 1'b1));
		twv <= 16'h0200;
		twe <= 5'h01;
		wait_n(2);
		twv <= 16'h0010;
		twe <= 5'h06;
		wait_n(2);
		twe <= 5'h00;
		teach <= 5'h10;
		wait_n(4);
		teach <= 5'h00;
		wait_n(6);
		rd_reg(8'h1C, d);
		check("bus twilight", d, 32'h0200);
		rd_reg(8'h5C, d);
		check("taught twilight", d, 32'h0100);
		pir <= 3'h1;
		wait_n(16);
		check("u0 start", st[0], 32'h1);
		check("u1 start", st[1], 32'h0);
		check("u2 start", st[2], 32'h1);
		check("u3 start", st[3], 32'h0);
		pir <= 3'h0;
		wait_n(8);
		pir <= 3'h1;
		wait_n(16);
		check("u0 retrigger", st[0], 32'h1);
		pir <= 3'h0;
	endtask : t_corridor
	task t_walk;
		logic [31:0] d;
		wr_reg(8'h00, 32'h3);
		hs_edge;
		rd_reg(8'h04, d);
		check("walk on", d[1], 1'b1);
		pir <= 3'h2;
		wait_n(16);
		check("led walk", led, 1'b1);
		check("u1 in walk", st[1], 32'h0);
		pir <= 3'h0;
		hs_edge;
		check("u0 stop", sp[0], 32'h1);
		check("u2 stop", sp[2], 32'h1);
		check("u1 stop", sp[1], 32'h0);
		check("led off", led, 1'b0);
	endtask : t_walk
	task t_download;
		logic [31:0] d;
		wr_reg(8'h00, 32'hB);
		dl <= 1'b1;
		wait_n(8);
		dl <= 1'b0;
		wait_n(8);
		rd_reg(8'h04, d);
		check("download walk", d[1], 1'b1);
		hs_edge;
		rd_reg(8'h04, d);
		check("handset exit", d[1], 1'b0);
	endtask : t_download
	// Sector 2, not in unit 0, still shows on the LED
	task t_led;
		wr_reg(8'h00, 32'h4);
		wr_reg(8'h10, ucfg(3'h1, 1'b0, 1'b1));
		wr_reg(8'h30, 32'h0);
		pir <= 3'h4;
		wait_n(12);
		check("led motion", led, 1'b1);
		check("u0 unassigned", st[0], 32'h1);
		pir <= 3'h0;
		wait_n(12);
		check("led idle", led, 1'b0);
		wr_reg(8'h00, 32'h0);
		pir <= 3'h4;
		wait_n(12);
		check("led masked", led, 1'b0);
		pir <= 3'h0;
	endtask : t_led
	task t_manual;
		mon <= 5'h08;
		wait_n(8);
		mon <= 5'h00;
		wait_n(8);
		check("manual on", st[3], 32'h1);
		moff <= 5'h08;
		wait_n(8);
		moff <= 5'h00;
		wait_n(8);
		check("manual off", sp[3], 32'h1);
	endtask : t_manual
	task t_reset;
		logic [31:0] d;
		wr_reg(8'h00, 32'h3);
		hs_edge;
		rd_reg(8'h04, d);
		check("walk again", d[1], 1'b1);
		nrst_in <= 1'b0;
		wait_n(3);
		nrst_in <= 1'b1;
		rd_reg(8'h04, d);
		check("walk cleared", d[1], 1'b0);
		check("led cleared", led, 1'b0);
	endtask : t_reset
	// Unit 0: eval delay 2 s, extra 2 s; restart on new motion
	task t_delay;
		wr_reg(8'h14, 32'h0002_0002);
		check("u0 objects", tel[0].objects, 32'h1);
		pir <= 3'h1;
		wait_n(12);
		check("u0 eval wait", st[0], 32'h1);
		wait_n(48);
		check("u0 eval start", st[0], 32'h2);
		pir <= 3'h0;
		wait_n(100);
		pir <= 3'h1;
		wait_n(4);
		pir <= 3'h0;
		wait_n(200);
		check("u0 restarted", sp[0], 32'h1);
		wait_n(60);
		check("u0 end", sp[0], 32'h2);
		check("u0 one start", st[0], 32'h2);
	endtask : t_delay
	// Unit 1 presence: sector 1, off delay 3 s above 0x0300
	task t_presence;
		wr_reg(8'h20, 32'h0000_B980);
		wr_reg(8'h28, 32'h0003_0300);
		check("u1 objects", tel[1].objects, 32'h3);
		pir <= 3'h2;
		wait_n(12);
		pir <= 3'h0;
		wait_n(4);
		check("u1 mid band", st[1], 32'h0);
		bright <= 16'h0008;
		wait_n(4);
		pir <= 3'h2;
		wait_n(12);
		check("u1 dark start", st[1], 32'h1);
		pir <= 3'h0;
		wait_n(180);
		check("u1 held", sp[1], 32'h0);
		wait_n(60);
		check("u1 end", sp[1], 32'h1);
		pir <= 3'h2;
		wait_n(12);
		check("u1 restart", st[1], 32'h2);
		bright <= 16'h0400;
		wait_n(100);
		check("u1 bright off", sp[1], 32'h2);
		check("u1 motion ignored", st[1], 32'h2);
		pir <= 3'h0;
		bright <= 16'h0100;
	endtask : t_presence
	// ==========================================================
	// Verdict and hang guard
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			tally_and_finish;
		end
	end
	initial begin
		wait_n(20);
		nrst_in <= 1'b1;
		t_regs;
		t_corridor;
		t_walk;
		t_download;
		t_led;
		t_manual;
		t_delay;
		t_presence;
		t_reset;
		tally_and_finish;
	end
endmodule : tb
